// ===== daq_adc_register_interface.sv
`timescale 1ns/100ps
// Behaviour
// - Answer the sixteen-byte aligned block that holds base
// - Decode offsets 0 to 14 to read/write functions, offset 15 has none
// - Result low byte, high nibble, zeros above
// - High byte bit four shows pending flag
// - Low byte read sets pending flag again
// - Channel register three bits, zero at power-up
// - Channel write switches multiplexer immediately
// - Gain register three bits, codes above four invalid
// - Any write to kick starts conversion
// - Interrupt flag set per conversion in interrupt-transfer modes, write clears
module daq_adc_register_interface #(
    parameter int unsigned ADDR_W = 10,
    parameter int unsigned RESULT_W = 12
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    // Host byte I/O cycle, one request per strobe pulse
    input wire logic [ADDR_W-1:0] io_addr,
    input wire logic [ADDR_W-1:0] base_addr,
    input wire logic io_rd_stb,
    input wire logic io_wr_stb,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_rvalid,
    // Converter side
    input wire logic conv_done_pin,
    input wire logic [RESULT_W-1:0] conv_data_pin,
    output logic conv_start,
    output logic [2:0] channel_select,
    output logic [2:0] gain_select,
    output logic gain_invalid,
    output logic [7:0] operating_mode,
    output logic interrupt_flag,
    // Digital ports and analog output value
    input wire logic [15:0] input_port_pin,
    output logic [15:0] output_port,
    output logic [11:0] output_value,
    // Timer counter access strobes, timer itself lives elsewhere
    output logic timer_wr,
    output logic [1:0] timer_sel,
    output logic [7:0] timer_wdata,
    input wire logic [7:0] timer_rdata
);

    // Synchronisers for pin inputs; stage one only feeds stage two
    logic done_s1;
    logic done_s2;
    logic done_prev;
    logic [15:0] inp_s1;
    logic [15:0] inp_s2;
    logic [RESULT_W-1:0] data_s1;
    logic [RESULT_W-1:0] data_s2;
    // Held result and status
    logic [RESULT_W-1:0] result;
    logic result_pending_flag;
    logic [7:0] dac_low_hold;
    daq_regs_pkg::bus_state_t bus_state;

    // Decode: inside block, and offset within block
    function automatic logic in_block(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
        in_block = (a[ADDR_W-1:daq_regs_pkg::OFS_W] == b[ADDR_W-1:daq_regs_pkg::OFS_W]);
    endfunction : in_block

    // Interrupt-transfer modes; every other code, the unused ones too, only polls
    function automatic logic irq_mode(input logic [7:0] m);
        irq_mode = (m[daq_regs_pkg::MODE_W-1:0] == daq_regs_pkg::MODE_EXT_IRQ)
            || (m[daq_regs_pkg::MODE_W-1:0] == daq_regs_pkg::MODE_PACER_IRQ);
    endfunction : irq_mode

    logic hit;
    logic [3:0] ofs;
    logic rd_cyc;
    logic wr_cyc;
    logic done_rise;
    assign hit = in_block(io_addr, base_addr);
    assign ofs = io_addr[daq_regs_pkg::OFS_W-1:0];
    assign rd_cyc = hit && io_rd_stb && !io_wr_stb;
    assign wr_cyc = hit && io_wr_stb && !io_rd_stb;
    assign done_rise = done_s2 && !done_prev;

    // Two-flop synchronisers for asynchronous pins
    // Data bus needs no gray code: it is only taken once done has settled
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            done_prev <= 1'b0;
            inp_s1 <= 16'h0000;
            inp_s2 <= 16'h0000;
            data_s1 <= '0;
            data_s2 <= '0;
        end else begin
            done_s1 <= conv_done_pin;
            done_s2 <= done_s1;
            done_prev <= done_s2;
            inp_s1 <= input_port_pin;
            inp_s2 <= inp_s1;
            data_s1 <= conv_data_pin;
            data_s2 <= data_s1;
        end
    end

    // Host cycle tracking, shows what the last strobe did
    // Both strobes together count as idle, so neither side wins
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            bus_state <= daq_regs_pkg::BUS_IDLE;
        end else begin
            case (1'b1)
                rd_cyc: bus_state <= daq_regs_pkg::BUS_READ;
                wr_cyc: bus_state <= daq_regs_pkg::BUS_WRITE;
                default: bus_state <= daq_regs_pkg::BUS_IDLE;
            endcase
        end
    end

    // Result capture and pending flag
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            result <= '0;
            result_pending_flag <= 1'b1;
        end else begin
            if (done_rise) begin
                result <= data_s2;
                result_pending_flag <= 1'b0;
            end else if (rd_cyc && ofs == daq_regs_pkg::OFS_RESULT_LOW) begin
                result_pending_flag <= 1'b1;
            end
        end
    end

    // Read data path, registered; one cycle after strobe
    // Reads outside the block leave the last read data standing
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            io_rdata <= daq_regs_pkg::BYTE_RESET;
            io_rvalid <= 1'b0;
        end else begin
            io_rvalid <= rd_cyc;
            if (rd_cyc) begin
                case (ofs)
                    daq_regs_pkg::OFS_TIMER_COUNT_ZERO,
                    daq_regs_pkg::OFS_TIMER_COUNT_ONE,
                    daq_regs_pkg::OFS_TIMER_COUNT_TWO: io_rdata <= timer_rdata;
                    daq_regs_pkg::OFS_RESULT_LOW: io_rdata <= result[7:0];
                    daq_regs_pkg::OFS_RESULT_HIGH: io_rdata <= {3'h0, result_pending_flag,
                        result[RESULT_W-1:8]};
                    daq_regs_pkg::OFS_INPUT_PORT_LOW: io_rdata <= inp_s2[7:0];
                    daq_regs_pkg::OFS_INPUT_PORT_HIGH: io_rdata <= inp_s2[15:8];
                    default: io_rdata <= daq_regs_pkg::BYTE_RESET;
                endcase
            end
        end
    end

    // Timer access strobes forwarded to the timer block
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            timer_wr <= 1'b0;
            timer_sel <= 2'h0;
            timer_wdata <= daq_regs_pkg::BYTE_RESET;
        end else begin
            timer_wr <= wr_cyc && (ofs <= daq_regs_pkg::OFS_TIMER_CONTROL);
            // unused reads ignored
            // Idle address lines and reads of offset 3 must not move the selection
            if ((wr_cyc && ofs <= daq_regs_pkg::OFS_TIMER_CONTROL)
                    || (rd_cyc && ofs < daq_regs_pkg::OFS_TIMER_CONTROL)) begin
                timer_sel <= ofs[1:0];
            end
            if (wr_cyc) begin
                timer_wdata <= io_wdata;
            end
        end
    end

    // Write-only control registers
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            channel_select <= daq_regs_pkg::CHANNEL_RESET;
            gain_select <= daq_regs_pkg::GAIN_RESET;
            gain_invalid <= 1'b0;
            operating_mode <= daq_regs_pkg::BYTE_RESET;
            output_port <= 16'h0000;
            output_value <= 12'h000;
            dac_low_hold <= daq_regs_pkg::BYTE_RESET;
        end else if (wr_cyc) begin
            case (ofs)
                daq_regs_pkg::OFS_CHANNEL_SELECT: channel_select <= io_wdata[2:0];
                daq_regs_pkg::OFS_GAIN_SELECT: begin
                    gain_select <= io_wdata[2:0];
                    gain_invalid <= io_wdata[2:0] > daq_regs_pkg::GAIN_MAX_VALID;
                end
                daq_regs_pkg::OFS_OPERATING_MODE: operating_mode <= io_wdata;
                daq_regs_pkg::OFS_OUTPUT_PORT_LOW: output_port[7:0] <= io_wdata;
                daq_regs_pkg::OFS_OUTPUT_PORT_HIGH: output_port[15:8] <= io_wdata;
                // Low byte waits; high byte updates the output in one step
                daq_regs_pkg::OFS_RESULT_LOW: dac_low_hold <= io_wdata;
                daq_regs_pkg::OFS_RESULT_HIGH: output_value <= {io_wdata[3:0], dac_low_hold};
                default: gain_invalid <= gain_invalid;
            endcase
        end
    end

    // Conversion start pulse and interrupt status flag
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            conv_start <= 1'b0;
            interrupt_flag <= 1'b0;
        end else begin
            conv_start <= wr_cyc && ofs == daq_regs_pkg::OFS_CONVERSION_KICK;
            // set wins over clear
            // Only the two interrupt-transfer modes raise the flag
            if (done_rise && irq_mode(operating_mode)) begin
                interrupt_flag <= 1'b1;
            end else if (wr_cyc && ofs == daq_regs_pkg::OFS_INTERRUPT_CLEAR) begin
                interrupt_flag <= 1'b0;
            end
        end
    end

    // Assertions
    sequence low_read_s;
        rd_cyc && ofs == daq_regs_pkg::OFS_RESULT_LOW && !done_rise;
    endsequence

    sequence kick_write_s;
        wr_cyc && ofs == daq_regs_pkg::OFS_CONVERSION_KICK;
    endsequence

    // Completion while an interrupt-transfer mode is selected
    sequence irq_done_s;
        done_rise && irq_mode(operating_mode);
    endsequence

    block_hit_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (io_rd_stb && !io_wr_stb && !hit) |=> !io_rvalid)
        else $error("read outside block answered");
    high_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (rd_cyc && ofs == daq_regs_pkg::OFS_RESULT_HIGH) |=> io_rdata[7:5] == 3'h0)
        else $error("high byte upper bits not zero");
    pending_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        done_rise |=> !result_pending_flag && result == $past(data_s2))
        else $error("completion did not clear pending");
    low_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        low_read_s |=> result_pending_flag)
        else $error("low read did not set pending");
    channel_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wr_cyc && ofs == daq_regs_pkg::OFS_CHANNEL_SELECT)
        |=> channel_select == $past(io_wdata[2:0]))
        else $error("channel not switched");
    gain_code_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        gain_invalid == (gain_select > daq_regs_pkg::GAIN_MAX_VALID))
        else $error("gain invalid flag wrong");
    kick_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        kick_write_s |=> conv_start ##1
        (!conv_start || $past(wr_cyc && ofs == daq_regs_pkg::OFS_CONVERSION_KICK)))
        else $error("kick pulse wrong");
    irq_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wr_cyc && ofs == daq_regs_pkg::OFS_INTERRUPT_CLEAR && !done_rise) |=> !interrupt_flag)
        else $error("interrupt flag not cleared");
    unused_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (rd_cyc && ofs >= daq_regs_pkg::OFS_INTERRUPT_CLEAR) |=> io_rdata == 8'h00
        && $stable(channel_select) && $stable(gain_select))
        else $error("unmapped read had effect");

    // A completion in interrupt-transfer mode must raise the status flag
    irq_set_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        irq_done_s |=> interrupt_flag)
        else $error("interrupt flag not set");
    // Polling modes never raise the status flag on their own
    irq_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (done_rise && !irq_mode(operating_mode) && !interrupt_flag) |=> !interrupt_flag)
        else $error("interrupt flag set in polling mode");
    // Valid pulse and cycle tracker must tell the same story
    read_valid_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        io_rvalid == (bus_state == daq_regs_pkg::BUS_READ))
        else $error("read valid disagrees with cycle tracker");
    // Low byte of the output value waits for the high byte
    dac_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wr_cyc && ofs == daq_regs_pkg::OFS_RESULT_LOW) |=> $stable(output_value))
        else $error("output value moved on low byte write");
    // Timer writes are forwarded with their data
    timer_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wr_cyc && ofs <= daq_regs_pkg::OFS_TIMER_CONTROL)
        |=> timer_wr && timer_wdata == $past(io_wdata))
        else $error("timer write not forwarded");
    // Offset 15 has no write function
    unused_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wr_cyc && ofs > daq_regs_pkg::OFS_OUTPUT_PORT_HIGH) |=> $stable(channel_select)
        && $stable(gain_select) && $stable(operating_mode) && $stable(output_port))
        else $error("unmapped write had effect");

endmodule : daq_adc_register_interface

// ===== daq_regs_pkg.sv
package daq_regs_pkg;
    // Address block size and decode width
    localparam int unsigned BLOCK_SIZE = 16;
    localparam int unsigned OFS_W = 4;
    // Register offsets within the block
    localparam logic [3:0] OFS_TIMER_COUNT_ZERO = 4'h0;
    localparam logic [3:0] OFS_TIMER_COUNT_ONE = 4'h1;
    localparam logic [3:0] OFS_TIMER_COUNT_TWO = 4'h2;
    localparam logic [3:0] OFS_TIMER_CONTROL = 4'h3;
    localparam logic [3:0] OFS_RESULT_LOW = 4'h4;
    localparam logic [3:0] OFS_RESULT_HIGH = 4'h5;
    localparam logic [3:0] OFS_INPUT_PORT_LOW = 4'h6;
    localparam logic [3:0] OFS_INPUT_PORT_HIGH = 4'h7;
    localparam logic [3:0] OFS_INTERRUPT_CLEAR = 4'h8;
    localparam logic [3:0] OFS_GAIN_SELECT = 4'h9;
    localparam logic [3:0] OFS_CHANNEL_SELECT = 4'ha;
    localparam logic [3:0] OFS_OPERATING_MODE = 4'hb;
    localparam logic [3:0] OFS_CONVERSION_KICK = 4'hc;
    localparam logic [3:0] OFS_OUTPUT_PORT_LOW = 4'hd;
    localparam logic [3:0] OFS_OUTPUT_PORT_HIGH = 4'he;
    // Field positions
    localparam int unsigned PENDING_BIT = 4;
    localparam int unsigned SEL_W = 3;
    localparam int unsigned MODE_IRQ_LSB = 4;
    // Converter mode field width and the two modes that raise end-of-conversion status
    localparam int unsigned MODE_W = 3;
    localparam logic [2:0] MODE_EXT_IRQ = 3'h3;
    localparam logic [2:0] MODE_PACER_IRQ = 3'h6;
    // Reset values and highest valid gain code
    localparam logic [2:0] CHANNEL_RESET = 3'h0;
    localparam logic [2:0] GAIN_RESET = 3'h0;
    localparam logic [2:0] GAIN_MAX_VALID = 3'h4;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // Host cycle decode states
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_READ = 3'b010,
        BUS_WRITE = 3'b100
    } bus_state_t;
endpackage : daq_regs_pkg

// ===== host_io_model.sv
`timescale 1ns/100ps
// Host processor doing byte I/O cycles, one strobe pulse per access
module host_io_model (
    input wire logic sys_clk,
    output logic [9:0] io_addr,
    output logic io_rd_stb,
    output logic io_wr_stb,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic io_rvalid
);
    // Idle bus at time zero
    initial begin
        io_addr = 10'h000;
        io_rd_stb = 1'b0;
        io_wr_stb = 1'b0;
        io_wdata = 8'h00;
    end

    // One access: drive after falling edge, release after the taking edge
    task automatic xfer(input logic wr, input logic [9:0] a, input logic [7:0] d,
            output logic [7:0] q, output logic v);
        @(negedge sys_clk);
        io_addr = a;
        io_wdata = d;
        io_wr_stb = wr;
        io_rd_stb = !wr;
        @(negedge sys_clk);
        io_wr_stb = 1'b0;
        io_rd_stb = 1'b0;
        // Read answer is a one-cycle pulse, so take it now
        q = io_rdata;
        v = io_rvalid;
        // Released bus no longer shows the last value
        io_addr = ~a;
        io_wdata = ~d;
    endtask : xfer
endmodule : host_io_model

// ===== tb_daq_adc_register_interface.sv
`timescale 1ns/100ps
module tb_daq_adc_register_interface;
    localparam logic [9:0] BASE = 10'h220;
    logic sys_clk, rst_b, conv_done_pin, conv_start, gain_invalid, interrupt_flag;
    logic io_rd_stb, io_wr_stb, io_rvalid, timer_wr;
    logic [9:0] io_addr;
    logic [7:0] io_wdata, io_rdata, operating_mode, timer_wdata, q;
    logic [11:0] conv_data_pin, output_value;
    logic [2:0] channel_select, gain_select;
    logic [15:0] output_port;
    logic [1:0] timer_sel;
    int fails = 0;
    int checks = 0;

    host_io_model i_host_io_model (.sys_clk(sys_clk), .io_addr(io_addr),
        .io_rd_stb(io_rd_stb), .io_wr_stb(io_wr_stb), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_rvalid(io_rvalid));

    // Base, input port and timer data are static, tied
    daq_adc_register_interface i_daq_adc_register_interface (.sys_clk(sys_clk),
        .rst_b(rst_b), .io_addr(io_addr), .base_addr(BASE), .io_rd_stb(io_rd_stb),
        .io_wr_stb(io_wr_stb), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_rvalid(io_rvalid), .conv_done_pin(conv_done_pin),
        .conv_data_pin(conv_data_pin), .conv_start(conv_start),
        .channel_select(channel_select), .gain_select(gain_select),
        .gain_invalid(gain_invalid), .operating_mode(operating_mode),
        .interrupt_flag(interrupt_flag), .input_port_pin(16'h5aa5),
        .output_port(output_port), .output_value(output_value), .timer_wr(timer_wr),
        .timer_sel(timer_sel), .timer_wdata(timer_wdata), .timer_rdata(8'h3c));

    // Free-running 125 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] ofs, input logic [7:0] d, input logic [9:0] b = BASE);
        logic v;
        i_host_io_model.xfer(1'b1, b + {6'h00, ofs}, d, q, v);
    endtask : wr

    task automatic rd(input logic [3:0] ofs, input logic [7:0] exp);
        logic v;
        i_host_io_model.xfer(1'b0, BASE + {6'h00, ofs}, 8'h00, q, v);
        check({7'h00, v, q}, {8'h01, exp});
    endtask : rd

    // Converter finishing: data settles before done rises
    task automatic convert(input logic [11:0] d);
        @(negedge sys_clk);
        conv_data_pin = d;
        repeat (4) @(negedge sys_clk);
        conv_done_pin = 1'b1;
        repeat (5) @(negedge sys_clk);
        conv_done_pin = 1'b0;
    endtask : convert

    // Power-up values and empty result
    task automatic test_reset();
        check({13'h0, channel_select}, 16'h0);
        check({13'h0, gain_select}, 16'h0);
        rd(4'h5, 8'h10);
    endtask : test_reset

    // Kick, result bytes, pending flag set again by low read
    task automatic test_result();
        wr(4'hc, 8'h00);
        check({15'h0, conv_start}, 16'h1);
        @(negedge sys_clk);
        check({15'h0, conv_start}, 16'h0);
        convert(12'habc);
        rd(4'h5, 8'h0a);
        rd(4'h4, 8'hbc);
        rd(4'h5, 8'h1a);
    endtask : test_result

    // Every channel and gain code, upper bits set and ignored
    task automatic test_selects();
        for (int i = 0; i < 8; i++) begin
            wr(4'ha, 8'hf8 | 8'(i));
            check({13'h0, channel_select}, 16'(i));
            wr(4'h9, 8'hf8 | 8'(i));
            check({12'h0, gain_invalid, gain_select}, 16'(i) | 16'(i > 4) << 3);
        end
    endtask : test_selects

    // Interrupt modes 3 and 6 set the flag, a write clears it, polling mode 1 does not set it
    task automatic test_interrupt();
        wr(4'hb, 8'h73);
        check({8'h0, operating_mode}, 16'h0073);
        convert(12'h123);
        check({15'h0, interrupt_flag}, 16'h1);
        wr(4'h8, 8'h5a);
        check({15'h0, interrupt_flag}, 16'h0);
        wr(4'hb, 8'h06);
        convert(12'h456);
        check({15'h0, interrupt_flag}, 16'h1);
        wr(4'h8, 8'h00);
        wr(4'hb, 8'h01);
        convert(12'h789);
        check({15'h0, interrupt_flag}, 16'h0);
    endtask : test_interrupt

    // Unmapped and out-of-block accesses, decoded ports
    task automatic test_decode();
        logic v;
        wr(4'ha, 8'h03, BASE + 10'h010);
        i_host_io_model.xfer(1'b0, BASE + 10'h014, 8'h00, q, v);
        check({15'h0, v}, 16'h0);
        wr(4'hf, 8'hff);
        rd(4'ha, 8'h00);
        check({13'h0, channel_select}, 16'h7);
        rd(4'h6, 8'ha5);
        wr(4'hd, 8'h81);
        wr(4'he, 8'h7e);
        check(output_port, 16'h7e81);
        rd(4'h0, 8'h3c);
        wr(4'h1, 8'h96);
        check({5'h0, timer_wr, timer_sel, timer_wdata}, 16'h0596);
        wr(4'h4, 8'h34);
        check({4'h0, output_value}, 16'h0000);
        wr(4'h5, 8'hf2);
        check({4'h0, output_value}, 16'h0234);
    endtask : test_decode

    // Verdict, reached from main sequence or watchdog
    task automatic finish_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    // Watchdog well beyond the expected run length
    initial begin
        #(20000 * 8);
        fails++;
        finish_test();
    end

    // Main sequence with six-cycle reset
    initial begin
        rst_b = 1'b0;
        conv_done_pin = 1'b0;
        conv_data_pin = 12'h000;
        repeat (6) @(negedge sys_clk);
        rst_b = 1'b1;
        test_reset();
        test_result();
        test_selects();
        test_interrupt();
        test_decode();
        finish_test();
    end
endmodule : tb_daq_adc_register_interface
